// file: include/ftr_pkg.sv
// package for the extended link service responder: codes, offsets, field positions
// assumes payload bytes arrive one per cycle, byte 0 first
package ftr_pkg;
    localparam logic [7:0] FTR_CODE_RRQ = 8'h12;
    localparam logic [7:0] FTR_CODE_TPRLO = 8'h24;
    localparam logic [7:0] FTR_CODE_ACC = 8'h02;
    localparam logic [7:0] FTR_PAGE_LEN = 8'h10;
    localparam logic [15:0] FTR_PAYLOAD_LEN = 16'h0014;
    localparam logic [7:0] FTR_TYPE_SCSI = 8'h08;
    localparam logic [7:0] FTR_TYPE_EXT = 8'h00;
    localparam logic [3:0] FTR_RESP_ACCEPT = 4'h1;
    localparam int FTR_HDR_BYTES = 4;
    localparam int FTR_PAGE_BYTES = 16;
    localparam int FTR_RRQ_ACC_BYTES = 4;
    localparam int FTR_OFS_FLAGS_HI = 2;
    localparam int FTR_OFS_PID0 = 13;
    localparam int FTR_BIT_OPA_VALID = 7;
    localparam int FTR_BIT_RPA_VALID = 6;
    localparam int FTR_BIT_PID_VALID = 5;
    localparam int FTR_BIT_GLOBAL = 4;
    localparam logic [7:0] FTR_MAX_PAGES = 8'h10;

    typedef enum logic [1:0] {
        FTR_ST_IDLE = 2'b00,
        FTR_ST_RX = 2'b01,
        FTR_ST_TX = 2'b10
    } ftr_state_t;
endpackage

// file: include/ftr_if.sv
// byte streams between initiator end and device end
// assumes one shared clock; last marks the final byte of a payload
`timescale 1ns/1ps
`default_nettype none
interface ftr_if;
    logic req_valid;
    logic [7:0] req_data;
    logic req_last;
    logic acc_valid;
    logic [7:0] acc_data;
    logic acc_last;
    logic busy;
    modport dev (input req_valid, input req_data, input req_last,
        output acc_valid, output acc_data, output acc_last, output busy);
    modport ini (output req_valid, output req_data, output req_last,
        input acc_valid, input acc_data, input acc_last, input busy);
endinterface
`default_nettype wire

// file: rtl/ftr_device.sv
// device end: takes request payloads, sends accepts, pulses image-pair logouts
// assumes the initiator does not send while busy is high
`timescale 1ns/1ps
`default_nettype none
module ftr_device
    import ftr_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    ftr_if.dev LINK,
    output logic LOGOUT_PULSE_O,
    output logic LOGOUT_ALL_O,
    output logic [23:0] LOGOUT_PORT_O,
    output logic QUAL_REUSE_OK_O
);
    ftr_state_t st_q;
    logic [7:0] cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] pages_q;
    logic [7:0] tx_cnt_q;
    logic [7:0] tx_len_q;
    logic [FTR_MAX_PAGES-1:0] pid_v_q;
    logic [FTR_MAX_PAGES-1:0] glob_q;
    logic [23:0] pid_q [FTR_MAX_PAGES];
    logic [7:0] cur_flag_q;
    logic [23:0] cur_pid_q;
    logic acc_valid_q;
    logic [7:0] acc_data_q;
    logic acc_last_q;
    logic lo_pulse_q;
    logic lo_all_q;
    logic [23:0] lo_port_q;
    logic busy_q;
    logic qual_ok_q;

    wire rx = LINK.req_valid;
    wire first = (st_q == FTR_ST_IDLE) && rx;
    wire [7:0] pos = first ? 8'h00 : cnt_q;
    wire [7:0] cmd = first ? LINK.req_data : cmd_q;
    wire in_page = (cmd == FTR_CODE_TPRLO) && (pos >= 8'(FTR_HDR_BYTES));
    wire [3:0] pofs = 4'(pos - 8'(FTR_HDR_BYTES));
    wire [7:0] pidx = 8'((pos - 8'(FTR_HDR_BYTES)) >> 4);
    wire page_end = in_page && (pofs == 4'(FTR_PAGE_BYTES - 1));
    wire [23:0] full_pid = {cur_pid_q[15:0], LINK.req_data};
    // a page is acted on once it is complete, and only if its global or pid valid flag is set
    wire do_logout = page_end && (cur_flag_q[FTR_BIT_GLOBAL] || cur_flag_q[FTR_BIT_PID_VALID]);
    // busy is registered, so it is computed one edge ahead from the move into send
    wire rx_state = (st_q == FTR_ST_IDLE) || (st_q == FTR_ST_RX);
    wire known_cmd = (cmd == FTR_CODE_RRQ) || (cmd == FTR_CODE_TPRLO);
    wire goes_tx = rx_state && rx && LINK.req_last && known_cmd;
    wire [7:0] tpos = tx_cnt_q;
    wire [3:0] tofs = 4'(tpos - 8'(FTR_HDR_BYTES));
    wire [3:0] tpg = 4'((tpos - 8'(FTR_HDR_BYTES)) >> 4);
    wire echo = pid_v_q[tpg] && !glob_q[tpg];
    wire [23:0] tpid = echo ? pid_q[tpg] : 24'h000000;
    logic [7:0] tbyte;

    always_comb
    begin
        tbyte = 8'h00;
        if (cmd_q == FTR_CODE_RRQ)
        begin
            tbyte = (tpos == 8'h00) ? FTR_CODE_ACC : 8'h00;
        end
        else if (tpos < 8'(FTR_HDR_BYTES))
        begin
            case (tpos[1:0])
                2'd0: tbyte = FTR_CODE_ACC;
                2'd1: tbyte = FTR_PAGE_LEN;
                2'd2: tbyte = FTR_PAYLOAD_LEN[15:8];
                default: tbyte = FTR_PAYLOAD_LEN[7:0];
            endcase
        end
        else
        begin
            case (tofs)
                4'd0: tbyte = FTR_TYPE_SCSI;
                4'd1: tbyte = FTR_TYPE_EXT;
                4'd2: tbyte = {2'b00, pid_v_q[tpg], glob_q[tpg], FTR_RESP_ACCEPT};
                4'd13: tbyte = tpid[23:16];
                4'd14: tbyte = tpid[15:8];
                4'd15: tbyte = tpid[7:0];
                default: tbyte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            st_q <= FTR_ST_IDLE;
            cnt_q <= 8'h00;
            cmd_q <= 8'h00;
            pages_q <= 8'h00;
            tx_cnt_q <= 8'h00;
            tx_len_q <= 8'h00;
            pid_v_q <= '0;
            glob_q <= '0;
            cur_flag_q <= 8'h00;
            cur_pid_q <= 24'h000000;
            acc_valid_q <= 1'b0;
            acc_data_q <= 8'h00;
            acc_last_q <= 1'b0;
            lo_pulse_q <= 1'b0;
            lo_all_q <= 1'b0;
            lo_port_q <= 24'h000000;
            busy_q <= 1'b0;
            qual_ok_q <= 1'b1;
        end
        else
        begin
            lo_pulse_q <= do_logout;
            busy_q <= goes_tx || (st_q == FTR_ST_TX);
            // reuse never waits for a reinstatement request
            qual_ok_q <= 1'b1;
            if (do_logout)
            begin
                lo_all_q <= cur_flag_q[FTR_BIT_GLOBAL];
                lo_port_q <= full_pid;
            end
            acc_valid_q <= 1'b0;
            acc_last_q <= 1'b0;
            case (st_q)
                FTR_ST_IDLE, FTR_ST_RX:
                begin
                    if (rx)
                    begin
                        cmd_q <= cmd;
                        cnt_q <= pos + 8'h01;
                        st_q <= FTR_ST_RX;
                        if (in_page && pofs == 4'(FTR_OFS_FLAGS_HI))
                            cur_flag_q <= LINK.req_data;
                        if (in_page && pofs >= 4'(FTR_OFS_PID0))
                            cur_pid_q <= full_pid;
                        if (page_end && pidx < FTR_MAX_PAGES)
                        begin
                            pid_v_q[pidx[3:0]] <= cur_flag_q[FTR_BIT_PID_VALID];
                            glob_q[pidx[3:0]] <= cur_flag_q[FTR_BIT_GLOBAL];
                            pid_q[pidx[3:0]] <= full_pid;
                            pages_q <= pidx + 8'h01;
                        end
                        if (LINK.req_last)
                        begin
                            tx_cnt_q <= 8'h00;
                            if (cmd == FTR_CODE_RRQ)
                            begin
                                tx_len_q <= 8'(FTR_RRQ_ACC_BYTES);
                                st_q <= FTR_ST_TX;
                            end
                            else if (cmd == FTR_CODE_TPRLO)
                            begin
                                tx_len_q <= 8'(FTR_HDR_BYTES) + ((pidx + (page_end ? 8'h01 : 8'h00)) << 4);
                                st_q <= FTR_ST_TX;
                            end
                            else
                                st_q <= FTR_ST_IDLE;
                        end
                    end
                end
                FTR_ST_TX:
                begin
                    acc_valid_q <= 1'b1;
                    acc_data_q <= tbyte;
                    acc_last_q <= (tx_cnt_q == tx_len_q - 8'h01);
                    tx_cnt_q <= tx_cnt_q + 8'h01;
                    if (tx_cnt_q == tx_len_q - 8'h01)
                        st_q <= FTR_ST_IDLE;
                end
                default: st_q <= FTR_ST_IDLE;
            endcase
        end
    end

    assign LINK.acc_valid = acc_valid_q;
    assign LINK.acc_data = acc_data_q;
    assign LINK.acc_last = acc_last_q;
    assign LINK.busy = busy_q;
    assign LOGOUT_PULSE_O = lo_pulse_q;
    assign LOGOUT_ALL_O = lo_all_q;
    assign LOGOUT_PORT_O = lo_port_q;
    assign QUAL_REUSE_OK_O = qual_ok_q;
endmodule
`default_nettype wire

// file: rtl/ftr_initiator.sv
// initiator end: serialises a reinstatement or a one-page logout request
// assumes the user waits for DONE_O before the next start
`timescale 1ns/1ps
`default_nettype none
module ftr_initiator
    import ftr_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    ftr_if.ini LINK,
    input wire logic START_RRQ_I,
    input wire logic START_TPRLO_I,
    input wire logic [23:0] SID_I,
    input wire logic [15:0] OXID_I,
    input wire logic [15:0] RXID_I,
    input wire logic [7:0] FLAGS_HI_I,
    input wire logic [23:0] PORT_ID_I,
    output logic DONE_O,
    output logic [7:0] ACC_BYTE_O,
    output logic ACC_VALID_O
);
    logic busy_q;
    logic is_lo_q;
    logic [7:0] cnt_q;
    logic [95:0] rrq_q;
    logic [7:0] flg_q;
    logic [23:0] pid_q;
    logic v_q;
    logic [7:0] d_q;
    logic l_q;
    logic done_q;
    logic [7:0] ab_q;
    logic av_q;
    logic [7:0] b;
    wire [7:0] len = is_lo_q ? 8'h14 : 8'h0c;
    wire [3:0] po = 4'(cnt_q - 8'h04);

    always_comb
    begin
        b = 8'h00;
        if (!is_lo_q)
            b = rrq_q[8'd95 - {cnt_q[4:0], 3'b000} -: 8];
        else if (cnt_q == 8'h00)
            b = FTR_CODE_TPRLO;
        else if (cnt_q == 8'h01)
            b = FTR_PAGE_LEN;
        else if (cnt_q == 8'h02)
            b = FTR_PAYLOAD_LEN[15:8];
        else if (cnt_q == 8'h03)
            b = FTR_PAYLOAD_LEN[7:0];
        else if (po == 4'd0)
            b = FTR_TYPE_SCSI;
        else if (po == 4'd1)
            b = FTR_TYPE_EXT;
        else if (po == 4'd2)
            b = flg_q; // single page
        else if (po == 4'd13)
            b = pid_q[23:16];
        else if (po == 4'd14)
            b = pid_q[15:8];
        else if (po == 4'd15)
            b = pid_q[7:0];
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            busy_q <= 1'b0;
            is_lo_q <= 1'b0;
            cnt_q <= 8'h00;
            rrq_q <= '0;
            flg_q <= 8'h00;
            pid_q <= 24'h000000;
            v_q <= 1'b0;
            d_q <= 8'h00;
            l_q <= 1'b0;
            done_q <= 1'b0;
            ab_q <= 8'h00;
            av_q <= 1'b0;
        end
        else
        begin
            v_q <= 1'b0;
            l_q <= 1'b0;
            done_q <= LINK.acc_valid && LINK.acc_last;
            av_q <= LINK.acc_valid;
            ab_q <= LINK.acc_data;
            if (!busy_q && !LINK.busy && (START_RRQ_I || START_TPRLO_I))
            begin
                busy_q <= 1'b1;
                is_lo_q <= START_TPRLO_I;
                cnt_q <= 8'h00;
                rrq_q <= {FTR_CODE_RRQ, 24'h000000, 8'h00, SID_I, OXID_I, RXID_I};
                flg_q <= FLAGS_HI_I;
                pid_q <= PORT_ID_I;
            end
            else if (busy_q)
            begin
                v_q <= 1'b1;
                d_q <= b;
                l_q <= (cnt_q == len - 8'h01);
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == len - 8'h01)
                    busy_q <= 1'b0;
            end
        end
    end

    assign LINK.req_valid = v_q;
    assign LINK.req_data = d_q;
    assign LINK.req_last = l_q;
    assign DONE_O = done_q;
    assign ACC_BYTE_O = ab_q;
    assign ACC_VALID_O = av_q;
endmodule
`default_nettype wire

// file: verif/ftr_props.sv
// checker for the request and accept byte streams between the two ends
// assumes one page per logout request and one clock for both ends
`timescale 1ns/1ps
`default_nettype none
module ftr_props
    import ftr_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic req_valid,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    input wire logic acc_valid,
    input wire logic [7:0] acc_data,
    input wire logic acc_last,
    input wire logic busy
);
    logic [7:0] req_cnt_q;
    logic [7:0] acc_cnt_q;
    logic [7:0] code_q;
    logic [7:0] rflags_q;
    logic [7:0] rlen_q;
    logic [23:0] pid_q;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            req_cnt_q <= 8'h00;
            acc_cnt_q <= 8'h00;
        end
        else
        begin
            if (req_valid)
                req_cnt_q <= req_last ? 8'h00 : req_cnt_q + 8'h01;
            if (acc_valid)
                acc_cnt_q <= acc_last ? 8'h00 : acc_cnt_q + 8'h01;
        end
    end
    // request fields kept so the accept can be judged against them
    always_ff @(posedge CLK_SYS_I)
    begin
        if (req_valid && req_cnt_q == 8'h00)
            code_q <= req_data;
        if (req_valid && req_cnt_q == 8'h06)
            rflags_q <= req_data;
        if (req_valid && req_cnt_q >= 8'h11 && req_cnt_q <= 8'h13)
            pid_q <= {pid_q[15:0], req_data};
        if (req_valid && req_last)
            rlen_q <= req_cnt_q + 8'h01;
    end
    wire logic [3:0] pofs = acc_cnt_q[3:0] - 4'h4;
    wire logic in_pg = acc_valid && code_q == FTR_CODE_TPRLO && acc_cnt_q >= 8'h04;
    wire logic pid_echo = rflags_q[FTR_BIT_PID_VALID] && !rflags_q[FTR_BIT_GLOBAL];
    wire logic [23:0] echo = pid_echo ? pid_q : 24'h000000;
    wire logic req_end = req_valid && req_last;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_rrq_accept_bytes: assert property (req_end && code_q == FTR_CODE_RRQ |->
        ##2 acc_valid && acc_data == 8'h02 ##1 (acc_valid && acc_data == 8'h00 && !acc_last) [*2]
        ##1 acc_valid && acc_data == 8'h00 && acc_last) else $error("bad reinstatement accept");
    a_logout_header: assert property (req_end && code_q == FTR_CODE_TPRLO |->
        ##2 acc_valid && acc_data == 8'h02 ##1 acc_data == 8'h10 ##1 acc_data == 8'h00
        ##1 acc_data == 8'h14) else $error("bad logout accept header");
    a_page_type: assert property (in_pg && pofs < 4'h2 |->
        acc_data == (pofs == 4'h0 ? 8'h08 : 8'h00)) else $error("bad page type");
    a_resp_flags_hi: assert property (in_pg && pofs == 4'h2 |->
        acc_data == {2'b00, rflags_q[5:4], FTR_RESP_ACCEPT}) else $error("bad flag byte");
    a_flags_lo_zero: assert property (in_pg && pofs == 4'h3 |->
        acc_data == 8'h00) else $error("low flag byte not zero");
    a_assoc_zero: assert property (in_pg && pofs >= 4'h4 && pofs <= 4'hc |->
        acc_data == 8'h00) else $error("associator byte not zero");
    a_port_echo: assert property (in_pg && pofs == 4'hd |->
        acc_data == echo[23:16] ##1 acc_data == echo[15:8] ##1 acc_data == echo[7:0])
        else $error("bad port id in accept");
    a_page_count: assert property (acc_valid && acc_last && code_q == FTR_CODE_TPRLO |->
        acc_cnt_q + 8'h01 == rlen_q) else $error("accept length differs from request");
    a_no_req_busy: assert property (busy |-> !req_valid)
        else $error("request byte while device busy");

    c_rrq: cover property (req_end && code_q == FTR_CODE_RRQ);
    c_global: cover property (in_pg && pofs == 4'h2 && acc_data[4]);
    c_echo: cover property (in_pg && pofs == 4'hd && pid_echo);
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench: both ends joined by the link, user side of the initiator driven
// assumes the initiator sends one page per logout request
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ftr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic start_rrq = 1'b0;
    logic start_tprlo = 1'b0;
    logic [23:0] sid = 24'h0a1b2c;
    logic [15:0] oxid = 16'h1234;
    logic [15:0] rxid = 16'hfedc;
    logic [7:0] flags = 8'h00;
    logic [23:0] pid = 24'h000000;
    logic done, acc_valid, logout_pulse, logout_all, qual_ok;
    logic [7:0] acc_byte;
    logic [23:0] logout_port;
    logic [23:0] echo;
    logic [7:0] req_q[$];
    logic [7:0] acc_q[$];
    logic [7:0] exp_q[$];
    int fails = 0;
    int n_tests = 0;
    int pulses;
    ftr_if link();
    ftr_device ftr_device_i(.CLK_SYS_I(clk_sys), .RST_I(rst), .LINK(link),
        .LOGOUT_PULSE_O(logout_pulse), .LOGOUT_ALL_O(logout_all),
        .LOGOUT_PORT_O(logout_port), .QUAL_REUSE_OK_O(qual_ok));
    ftr_initiator ftr_initiator_i(.CLK_SYS_I(clk_sys), .RST_I(rst), .LINK(link),
        .START_RRQ_I(start_rrq), .START_TPRLO_I(start_tprlo), .SID_I(sid), .OXID_I(oxid),
        .RXID_I(rxid), .FLAGS_HI_I(flags), .PORT_ID_I(pid), .DONE_O(done),
        .ACC_BYTE_O(acc_byte), .ACC_VALID_O(acc_valid));
    ftr_props ftr_props_i(.CLK_SYS_I(clk_sys), .RST_I(rst), .req_valid(link.req_valid),
        .req_data(link.req_data), .req_last(link.req_last), .acc_valid(link.acc_valid),
        .acc_data(link.acc_data), .acc_last(link.acc_last), .busy(link.busy));
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one whole exchange; collects both streams until two cycles after done
    task automatic xfer(input logic tprlo);
        int tail;
        req_q.delete();
        acc_q.delete();
        pulses = 0;
        tail = -1;
        start_rrq = !tprlo;
        start_tprlo = tprlo;
        @(negedge clk_sys);
        start_rrq = 1'b0;
        start_tprlo = 1'b0;
        for (int n = 0; n < 200 && tail != 0; n++)
        begin
            if (link.req_valid === 1'b1)
                req_q.push_back(link.req_data);
            if (acc_valid === 1'b1)
                acc_q.push_back(acc_byte);
            if (logout_pulse === 1'b1)
                pulses++;
            if (tail > 0)
                tail--;
            if (done === 1'b1 && tail < 0)
                tail = 2;
            @(negedge clk_sys);
        end
        if (tail != 0)
        begin
            fails++;
            print_verdict();
        end
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk(qual_ok, 1'b1);
        xfer(1'b0);
        chk(24'(req_q.size()), 24'h00000c);
        exp_q = '{8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h1b, 8'h2c, 8'h12, 8'h34, 8'hfe, 8'hdc};
        for (int i = 0; i < 12; i++)
            chk(req_q[i], exp_q[i]);
        chk(24'(acc_q.size()), 24'h000004);
        exp_q = '{8'h02, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++)
            chk(acc_q[i], exp_q[i]);
        chk(qual_ok, 1'b1);
        $display("test reinstatement done");
        // bit 0 port valid, bit 1 global, bit 2 both associator valids
        for (int k = 0; k < 8; k++)
        begin
            flags = {k[2], k[2], k[0], k[1], 4'h0};
            pid = 24'h102030 + 24'(k);
            xfer(1'b1);
            chk(24'(req_q.size()), 24'h000014);
            exp_q = '{8'h24, 8'h10, 8'h00, 8'h14, 8'h08, 8'h00, flags};
            for (int i = 0; i < 7; i++)
                chk(req_q[i], exp_q[i]);
            echo = (k[0] && !k[1]) ? pid : 24'h000000;
            exp_q = '{8'h02, 8'h10, 8'h00, 8'h14, 8'h08, 8'h00, {2'b00, k[0], k[1], 4'h1}};
            repeat (10) exp_q.push_back(8'h00);
            exp_q.push_back(echo[23:16]);
            exp_q.push_back(echo[15:8]);
            exp_q.push_back(echo[7:0]);
            chk(24'(acc_q.size()), 24'h000014);
            for (int i = 0; i < 20; i++)
                chk(acc_q[i], exp_q[i]);
            chk(pulses, k[0] | k[1]);
            if (k[0] || k[1])
                chk(logout_all, k[1]);
            if (k[0] && !k[1])
                chk(logout_port, pid);
            $display("test logout %0d done", k);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
